// >>> hw/mtw_mmu.sv
`timescale 1ns/1ns
module mtw_mmu
  import mtw_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Core access
  input  wire logic        req_i,
  input  wire logic [31:0] vaddr_i,
  input  wire logic        write_i,
  input  wire logic        priv_i,
  input  wire logic        data_i,
  output logic             ack_o,
  output logic             abort_o,
  output logic             busy_o,
  output logic [31:0]      paddr_o,
  output logic             cachable_o,
  output logic             bufferable_o,
  // Coprocessor transfers
  input  wire logic        cp_wr_i,
  input  wire logic        cp_rd_i,
  input  wire logic [3:0]  cp_reg_i,
  input  wire logic [2:0]  cp_op_i,
  input  wire logic [31:0] cp_wdata_i,
  output logic [31:0]      cp_rdata_o,
  // Table walk memory port
  output logic             walk_req_o,
  output logic [29:0]      walk_addr_o,
  input  wire logic        walk_ack_i,
  input  wire logic        walk_err_i,
  input  wire logic [31:0] walk_data_i
);

  // ***********************
  // Registers
  // ***********************
  logic [31:0] control_reg;
  logic [31:0] table_base_reg;
  logic [31:0] domain_rights_reg;
  logic [31:0] fault_status_reg;
  logic [31:0] fault_address_reg;
  logic [31:0] process_id_relocation_reg;
  mtw_state_t  state_reg;
  logic [31:0] va_reg;
  logic        write_reg;
  logic        priv_reg;
  logic        data_reg;
  logic [3:0]  l1_dom_reg;
  logic [TLB_IDX_W-1:0] victim_reg;

  // Translation cache storage
  logic [TLB_ENTRIES-1:0] e_valid_reg;
  logic [1:0]  e_size_reg [TLB_ENTRIES];
  logic [19:0] e_tag_reg  [TLB_ENTRIES];
  logic [19:0] e_ppn_reg  [TLB_ENTRIES];
  logic [3:0]  e_dom_reg  [TLB_ENTRIES];
  logic [7:0]  e_ap_reg   [TLB_ENTRIES];
  logic [1:0]  e_cb_reg   [TLB_ENTRIES];

  // ***********************
  // Relocation and lookup
  // ***********************
  logic [31:0] va_reloc;
  logic [TLB_ENTRIES-1:0] hit_vec;
  logic [TLB_ENTRIES-1:0] inv_vec;
  logic        hit;
  logic [TLB_IDX_W-1:0] hit_idx;

  // Low 32MB of virtual space is moved into the process slot
  always_comb begin
    va_reloc = vaddr_i;
    if (vaddr_i[31:PID_LSB] == '0) begin
      va_reloc[31:PID_LSB] = process_id_relocation_reg[31:PID_LSB];
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < TLB_ENTRIES; gi++) begin : g_ent
      mtw_match u_hit (
        .valid_i (e_valid_reg[gi]),
        .size_i  (e_size_reg[gi]),
        .tag_i   (e_tag_reg[gi]),
        .va_i    (va_reg[31:12]),
        .hit_o   (hit_vec[gi])
      );
      // Second comparator so single invalidation never waits on a lookup
      mtw_match u_inv (
        .valid_i (e_valid_reg[gi]),
        .size_i  (e_size_reg[gi]),
        .tag_i   (e_tag_reg[gi]),
        .va_i    (cp_wdata_i[31:12]),
        .hit_o   (inv_vec[gi])
      );
    end
  endgenerate

  always_comb begin
    hit     = 1'b0;
    hit_idx = '0;
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      if (hit_vec[i] && !hit) begin
        hit     = 1'b1;
        hit_idx = TLB_IDX_W'(i);
      end
    end
  end

  // ***********************
  // Permission check
  // ***********************
  logic [1:0]  h_size;
  logic [3:0]  h_dom;
  logic [1:0]  h_rights;
  logic [1:0]  h_ap;
  logic        h_page;
  logic        ap_ok;
  logic [31:0] h_paddr;

  always_comb begin
    h_size   = e_size_reg[hit_idx];
    h_dom    = e_dom_reg[hit_idx];
    h_page   = (h_size != SZ_SECTION);
    h_rights = domain_rights_reg[{h_dom, 1'b0} +: 2];
    case (h_size)
      SZ_SMALL: h_ap = e_ap_reg[hit_idx][{va_reg[11:10], 1'b0} +: 2];
      SZ_LARGE: h_ap = e_ap_reg[hit_idx][{va_reg[15:14], 1'b0} +: 2];
      default:  h_ap = e_ap_reg[hit_idx][1:0];
    endcase
    case (h_ap)
      2'h0: begin
        if (control_reg[CTL_SYS] && !control_reg[CTL_ROM]) begin
          ap_ok = priv_reg && !write_reg;
        end else if (control_reg[CTL_ROM] && !control_reg[CTL_SYS]) begin
          ap_ok = !write_reg;
        end else begin
          ap_ok = 1'b0;
        end
      end
      2'h1:    ap_ok = priv_reg;
      2'h2:    ap_ok = priv_reg || !write_reg;
      default: ap_ok = 1'b1;
    endcase
    case (h_size)
      SZ_SECTION: h_paddr = {e_ppn_reg[hit_idx][19:8], va_reg[19:0]};
      SZ_LARGE:   h_paddr = {e_ppn_reg[hit_idx][19:4], va_reg[15:0]};
      default:    h_paddr = {e_ppn_reg[hit_idx], va_reg[11:0]};
    endcase
  end

  // ***********************
  // Walk descriptor decode
  // ***********************
  logic        install;
  logic [1:0]  new_size;
  logic [19:0] new_ppn;
  logic [3:0]  new_dom;
  logic [7:0]  new_ap;
  logic        walk_fault;
  logic [3:0]  walk_code;
  logic [3:0]  walk_dom;

  always_comb begin
    install    = 1'b0;
    walk_fault = 1'b0;
    walk_code  = FS_TRANS_SEC;
    walk_dom   = walk_data_i[8:5];
    new_size   = SZ_SECTION;
    new_ppn    = {walk_data_i[31:20], 8'h00};
    new_dom    = walk_data_i[8:5];
    new_ap     = {4{walk_data_i[11:10]}};
    if (state_reg == ST_WALK1 && walk_ack_i) begin
      if (walk_err_i) begin
        walk_fault = 1'b1;
        walk_code  = FS_EXT_L1;
      end else if (walk_data_i[1:0] == DESC_SECTION) begin
        install = 1'b1;
      end else if (walk_data_i[1:0] != DESC_COARSE) begin
        walk_fault = 1'b1;
      end
    end else if (state_reg == ST_WALK2 && walk_ack_i) begin
      walk_dom = l1_dom_reg;
      new_dom  = l1_dom_reg;
      new_ap   = walk_data_i[11:4];
      new_ppn  = walk_data_i[31:12];
      if (walk_err_i) begin
        walk_fault = 1'b1;
        walk_code  = FS_EXT_L2;
      end else if (walk_data_i[1:0] == DESC_LARGE) begin
        install  = 1'b1;
        new_size = SZ_LARGE;
        new_ppn  = {walk_data_i[31:16], 4'h0};
      end else if (walk_data_i[1:0] == DESC_SMALL) begin
        install  = 1'b1;
        new_size = SZ_SMALL;
      end else begin
        walk_fault = 1'b1;
        walk_code  = FS_TRANS_PAGE;
      end
    end
  end

  // ***********************
  // Access sequencing
  // ***********************
  logic        fault_now;
  logic [3:0]  fault_code;
  logic [3:0]  fault_dom;

  always_comb begin
    fault_now  = walk_fault;
    fault_code = walk_code;
    fault_dom  = walk_dom;
    if (state_reg == ST_LOOKUP && control_reg[CTL_MMU_EN] && hit) begin
      fault_dom = h_dom;
      if (h_rights == DOM_MANAGER) begin
        fault_now = 1'b0;
      end else if (h_rights == DOM_CLIENT) begin
        fault_now  = !ap_ok;
        fault_code = h_page ? FS_PERM_PAGE : FS_PERM_SEC;
      end else begin
        fault_now  = 1'b1;
        fault_code = h_page ? FS_DOM_PAGE : FS_DOM_SEC;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE:   if (req_i) state_reg <= ST_LOOKUP;
        ST_LOOKUP: begin
          if (!control_reg[CTL_MMU_EN] || hit) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= ST_WALK1;
          end
        end
        ST_WALK1: begin
          if (walk_fault) begin
            state_reg <= ST_IDLE;
          end else if (walk_ack_i) begin
            state_reg <= install ? ST_LOOKUP : ST_WALK2;
          end
        end
        ST_WALK2:  if (walk_ack_i) state_reg <= walk_fault ? ST_IDLE : ST_LOOKUP;
        default:   state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      va_reg     <= RST_WORD;
      write_reg  <= 1'b0;
      priv_reg   <= 1'b0;
      data_reg   <= 1'b0;
      l1_dom_reg <= 4'h0;
    end else begin
      if (state_reg == ST_IDLE && req_i) begin
        va_reg    <= va_reloc;
        write_reg <= write_i;
        priv_reg  <= priv_i;
        data_reg  <= data_i;
      end
      if (state_reg == ST_WALK1 && walk_ack_i) l1_dom_reg <= walk_data_i[8:5];
    end
  end

  // Core-facing answer
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_o        <= 1'b0;
      abort_o      <= 1'b0;
      busy_o       <= 1'b0;
      paddr_o      <= RST_WORD;
      cachable_o   <= 1'b0;
      bufferable_o <= 1'b0;
    end else begin
      ack_o   <= 1'b0;
      abort_o <= 1'b0;
      if (state_reg == ST_IDLE && req_i) busy_o <= 1'b1;
      if (state_reg == ST_LOOKUP && !control_reg[CTL_MMU_EN]) begin
        ack_o        <= 1'b1;
        busy_o       <= 1'b0;
        paddr_o      <= va_reg;
        cachable_o   <= 1'b0;
        bufferable_o <= 1'b0;
      end else if ((state_reg == ST_LOOKUP && hit) || walk_fault) begin
        ack_o   <= 1'b1;
        busy_o  <= 1'b0;
        abort_o <= fault_now;
        if (!fault_now) begin
          paddr_o      <= h_paddr;
          cachable_o   <= e_cb_reg[hit_idx][1];
          bufferable_o <= e_cb_reg[hit_idx][0];
        end
      end
    end
  end

  // Walk memory port
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      walk_req_o  <= 1'b0;
      walk_addr_o <= '0;
    end else if (state_reg == ST_LOOKUP && control_reg[CTL_MMU_EN] && !hit) begin
      walk_req_o  <= 1'b1;
      walk_addr_o <= {table_base_reg[31:TTB_LSB], va_reg[31:20]};
    end else if (state_reg == ST_WALK1 && walk_ack_i && !walk_fault && !install) begin
      walk_req_o  <= 1'b1;
      walk_addr_o <= {walk_data_i[31:10], va_reg[19:12]};
    end else if (walk_ack_i) begin
      walk_req_o  <= 1'b0;
    end
  end

  // ***********************
  // Translation cache update
  // ***********************
  logic cp_inv;
  assign cp_inv = cp_wr_i && (cp_reg_i == CR_INVALIDATE);

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      e_valid_reg <= '0;
      victim_reg  <= '0;
    end else begin
      if (cp_inv && cp_op_i == INV_ALL) begin
        e_valid_reg <= '0;
      end else if (cp_inv && cp_op_i == INV_SINGLE) begin
        e_valid_reg <= e_valid_reg & ~inv_vec;
      end
      // Install wins over a same-cycle invalidate of the victim
      if (install) begin
        e_valid_reg[victim_reg] <= 1'b1;
        victim_reg              <= victim_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (install) begin
      e_size_reg[victim_reg] <= new_size;
      e_tag_reg[victim_reg]  <= va_reg[31:12];
      e_ppn_reg[victim_reg]  <= new_ppn;
      e_dom_reg[victim_reg]  <= new_dom;
      e_ap_reg[victim_reg]   <= new_ap;
      e_cb_reg[victim_reg]   <= walk_data_i[3:2];
    end
  end

  // ***********************
  // Coprocessor register file
  // ***********************
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      control_reg               <= RST_WORD;
      table_base_reg            <= RST_WORD;
      domain_rights_reg         <= RST_WORD;
      process_id_relocation_reg <= RST_WORD;
    end else if (cp_wr_i) begin
      case (cp_reg_i)
        CR_CONTROL:    control_reg               <= cp_wdata_i;
        CR_TABLE_BASE: table_base_reg            <= cp_wdata_i;
        CR_DOMAIN:     domain_rights_reg         <= cp_wdata_i;
        CR_PROCESS_ID: process_id_relocation_reg <= cp_wdata_i;
        default:       ;
      endcase
    end
  end

  // Prefetch aborts leave the fault record alone
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fault_status_reg  <= RST_WORD;
      fault_address_reg <= RST_WORD;
    end else if (fault_now && data_reg) begin
      fault_status_reg  <= {24'h0, fault_dom, fault_code};
      fault_address_reg <= va_reg;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cp_rdata_o <= RST_WORD;
    end else if (cp_rd_i) begin
      case (cp_reg_i)
        CR_CONTROL:    cp_rdata_o <= control_reg;
        CR_TABLE_BASE: cp_rdata_o <= table_base_reg;
        CR_DOMAIN:     cp_rdata_o <= domain_rights_reg;
        CR_FAULT_STAT: cp_rdata_o <= fault_status_reg;
        CR_FAULT_ADDR: cp_rdata_o <= fault_address_reg;
        CR_PROCESS_ID: cp_rdata_o <= process_id_relocation_reg;
        default:       cp_rdata_o <= RST_WORD;
      endcase
    end
  end

endmodule

// >>> hw/mtw_pkg.sv
package mtw_pkg;

  // ***********************
  // Coprocessor register numbers
  // ***********************
  localparam logic [3:0] CR_CONTROL    = 4'h1;
  localparam logic [3:0] CR_TABLE_BASE = 4'h2;
  localparam logic [3:0] CR_DOMAIN     = 4'h3;
  localparam logic [3:0] CR_FAULT_STAT = 4'h5;
  localparam logic [3:0] CR_FAULT_ADDR = 4'h6;
  localparam logic [3:0] CR_INVALIDATE = 4'h8;
  localparam logic [3:0] CR_PROCESS_ID = 4'hd;

  // Invalidate operation codes
  localparam logic [2:0] INV_ALL    = 3'h0;
  localparam logic [2:0] INV_SINGLE = 3'h1;

  // Control register bit positions
  localparam int CTL_MMU_EN = 0;
  localparam int CTL_SYS    = 8;
  localparam int CTL_ROM    = 9;

  // ***********************
  // Reset values and sizes
  // ***********************
  localparam logic [31:0] RST_WORD     = 32'h0000_0000;
  localparam int          TLB_ENTRIES  = 64;
  localparam int          TLB_IDX_W    = 6;
  localparam int          TTB_LSB      = 14;
  localparam int          PID_LSB      = 25;

  // Descriptor type field values
  localparam logic [1:0] DESC_INVALID = 2'h0;
  localparam logic [1:0] DESC_COARSE  = 2'h1;
  localparam logic [1:0] DESC_SECTION = 2'h2;
  localparam logic [1:0] DESC_LARGE   = 2'h1;
  localparam logic [1:0] DESC_SMALL   = 2'h2;

  // Mapping sizes held per entry
  localparam logic [1:0] SZ_SECTION = 2'h0;
  localparam logic [1:0] SZ_LARGE   = 2'h1;
  localparam logic [1:0] SZ_SMALL   = 2'h2;

  // Domain rights
  localparam logic [1:0] DOM_NONE    = 2'h0;
  localparam logic [1:0] DOM_CLIENT  = 2'h1;
  localparam logic [1:0] DOM_MANAGER = 2'h3;

  // Fault status codes, bit 0 clear only for external aborts on the walk
  localparam logic [3:0] FS_TRANS_SEC  = 4'h5;
  localparam logic [3:0] FS_TRANS_PAGE = 4'h7;
  localparam logic [3:0] FS_DOM_SEC    = 4'h9;
  localparam logic [3:0] FS_DOM_PAGE   = 4'hb;
  localparam logic [3:0] FS_PERM_SEC   = 4'hd;
  localparam logic [3:0] FS_PERM_PAGE  = 4'hf;
  localparam logic [3:0] FS_EXT_L1     = 4'hc;
  localparam logic [3:0] FS_EXT_L2     = 4'he;

  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_LOOKUP = 2'b01,
    ST_WALK1  = 2'b11,
    ST_WALK2  = 2'b10
  } mtw_state_t;

endpackage

// >>> hw/mtw_match.sv
`timescale 1ns/1ns
module mtw_match
  import mtw_pkg::*;
(
  // Entry contents
  input  wire logic        valid_i,
  input  wire logic [1:0]  size_i,
  input  wire logic [19:0] tag_i,
  // Address to compare
  input  wire logic [19:0] va_i,
  // Result
  output logic             hit_o
);

  // ***********************
  // Size-dependent tag compare
  // ***********************
  always_comb begin
    case (size_i)
      SZ_SECTION: hit_o = valid_i && (tag_i[19:8] == va_i[19:8]);
      SZ_LARGE:   hit_o = valid_i && (tag_i[19:4] == va_i[19:4]);
      SZ_SMALL:   hit_o = valid_i && (tag_i == va_i);
      default:    hit_o = 1'b0;
    endcase
  end

endmodule

// >>> verif/mtw_mmu_properties.sv
`timescale 1ns/1ns
module mtw_mmu_properties
  import mtw_pkg::*;
(
  // Clock, reset, core side and coprocessor writes
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        req_i,
  input  wire logic [31:0] vaddr_i,
  input  wire logic        cp_wr_i,
  input  wire logic [3:0]  cp_reg_i,
  input  wire logic [31:0] cp_wdata_i,
  input  wire logic        ack_o,
  input  wire logic        abort_o,
  input  wire logic        busy_o,
  input  wire logic [31:0] paddr_o,
  // Walk port
  input  wire logic        walk_req_o,
  input  wire logic [29:0] walk_addr_o,
  input  wire logic        walk_ack_i,
  input  wire logic        walk_err_i,
  input  wire logic [31:0] walk_data_i
);
  logic [31:0] base_q;
  logic [31:0] ctl_q;
  logic [31:0] va_q;
  logic [31:0] pid_q;
  logic [31:0] desc_q;
  logic [1:0]  walks_q;
  wire         taken   = req_i && !busy_o && !ack_o;
  wire         fetched = walk_ack_i && walk_req_o && !walk_err_i;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      base_q  <= '0;
      ctl_q   <= '0;
      va_q    <= '0;
      pid_q   <= '0;
      desc_q  <= '0;
      walks_q <= 2'd0;
    end else begin
      if (cp_wr_i && cp_reg_i == CR_TABLE_BASE) base_q <= cp_wdata_i;
      if (cp_wr_i && cp_reg_i == CR_CONTROL) ctl_q <= cp_wdata_i;
      if (cp_wr_i && cp_reg_i == CR_PROCESS_ID) pid_q <= cp_wdata_i;
      // Low addresses are seen after process relocation
      if (taken && vaddr_i[31:PID_LSB] == '0) begin
        va_q <= {pid_q[31:PID_LSB], vaddr_i[PID_LSB-1:0]};
      end else if (taken) begin
        va_q <= vaddr_i;
      end
      if (taken) walks_q <= 2'd0;
      else if (walk_ack_i && walk_req_o) walks_q <= walks_q + 2'd1;
      if (fetched && walks_q == 2'd0) desc_q <= walk_data_i;
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  sequence s_l1_ack(t);
    fetched && walks_q == 2'd0 && walk_data_i[1:0] == t;
  endsequence
  sequence s_answer;
    !walk_req_o throughout ##[0:3] ack_o;
  endsequence

  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  chk_abort_ack: assert property (abort_o |-> ack_o)
    else $error("abort without ack");
  chk_walk_stall: assert property (walk_req_o |-> busy_o && !ack_o)
    else $error("core released during walk");
  chk_walk_hold: assert property (walk_req_o && !walk_ack_i |=>
    walk_req_o && $stable(walk_addr_o))
    else $error("walk fetch dropped early");
  // A page table answer chains straight into the level two fetch
  chk_walk_drop: assert property (walk_ack_i && walk_req_o &&
    (!fetched || walks_q != 2'd0 || walk_data_i[1:0] != 2'h1) |=> !walk_req_o)
    else $error("walk fetch kept after ack");
  chk_l1_addr: assert property ($rose(walk_req_o) && walks_q == 2'd0 |->
    walk_addr_o == {base_q[31:14], va_q[31:20]})
    else $error("level one address wrong");
  chk_section_done: assert property (s_l1_ack(2'h2) |=> s_answer)
    else $error("section walk not finished");
  chk_page_fetch: assert property (s_l1_ack(2'h1) |=> ##[0:3]
    (walk_req_o && walk_addr_o == {desc_q[31:10], va_q[19:12]}))
    else $error("level two fetch missing");
  chk_bad_desc: assert property (s_l1_ack(2'h0) |=> s_answer ##0 abort_o)
    else $error("invalid descriptor not aborted");
  chk_off_pass: assert property (taken && !ctl_q[CTL_MMU_EN] |-> ##2
    (ack_o && !abort_o && paddr_o == va_q))
    else $error("untranslated address changed");
endmodule

bind mtw_mmu mtw_mmu_properties u_chk (.mclk_i, .reset_i, .req_i, .vaddr_i, .cp_wr_i, .cp_reg_i,
  .cp_wdata_i, .ack_o, .abort_o, .busy_o, .paddr_o, .walk_req_o, .walk_addr_o, .walk_ack_i,
  .walk_err_i, .walk_data_i);

// >>> verif/mtw_walk_mem.sv
`timescale 1ns/1ns
module mtw_walk_mem
  import mtw_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  // Walk port
  input  wire logic        walk_req_i,
  input  wire logic [29:0] walk_addr_i,
  output logic             walk_ack_o,
  output logic             walk_err_o,
  output logic [31:0]      walk_data_o
);
  logic [31:0] mem [logic [29:0]];
  int          delay    = 0;
  int          wait_q   = 0;
  int          walks    = 0;
  logic [29:0] err_addr = '1;

  // Unwritten words give an identity section, domain 0, full access
  function automatic logic [31:0] word(input logic [29:0] a);
    return mem.exists(a) ? mem[a] : {a[11:0], 20'h00c12};
  endfunction

  // Data toggles outside answers so stale values never look valid
  always @(posedge mclk_i) begin
    if (reset_i) begin
      walk_ack_o  <= 1'b0;
      walk_err_o  <= 1'b0;
      walk_data_o <= 32'h0;
      wait_q      <= 0;
    end else if (!walk_req_i || walk_ack_o || wait_q < delay) begin
      walk_ack_o  <= 1'b0;
      walk_err_o  <= 1'b0;
      walk_data_o <= ~walk_data_o;
      wait_q      <= (walk_req_i && !walk_ack_o) ? wait_q + 1 : 0;
    end else begin
      walk_ack_o  <= 1'b1;
      walk_err_o  <= (walk_addr_i == err_addr);
      walk_data_o <= word(walk_addr_i);
      walks       <= walks + 1;
    end
  end
endmodule

// >>> verif/mtw_mmu_tb.sv
`timescale 1ns/1ns
module mtw_mmu_tb;
  import mtw_pkg::*;
  logic mclk_i = 0, reset_i = 1, req_i = 0, write_i = 0, priv_i = 1, data_i = 0;
  logic cp_wr_i = 0, cp_rd_i = 0, ack_o, abort_o, busy_o, cachable_o, bufferable_o;
  logic walk_req_o, walk_ack_i, walk_err_i;
  logic [3:0]  cp_reg_i = 0;
  logic [2:0]  cp_op_i = 0;
  logic [29:0] walk_addr_o;
  logic [31:0] vaddr_i = 0, cp_wdata_i = 0, paddr_o, cp_rdata_o, walk_data_i;
  int          compares = 0, miscompares = 0;

  mtw_mmu u_dut (.mclk_i, .reset_i, .req_i, .vaddr_i, .write_i, .priv_i, .data_i, .ack_o,
    .abort_o, .busy_o, .paddr_o, .cachable_o, .bufferable_o, .cp_wr_i, .cp_rd_i, .cp_reg_i,
    .cp_op_i, .cp_wdata_i, .cp_rdata_o, .walk_req_o, .walk_addr_o, .walk_ack_i, .walk_err_i,
    .walk_data_i);
  mtw_walk_mem u_mem (.mclk_i, .reset_i, .walk_req_i(walk_req_o), .walk_addr_i(walk_addr_o),
    .walk_ack_o(walk_ack_i), .walk_err_o(walk_err_i), .walk_data_o(walk_data_i));

  // ***********************
  // Shared tasks
  // ***********************
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cp_write(input logic [3:0] r, input logic [2:0] op, input logic [31:0] d);
    @(posedge mclk_i);
    cp_wr_i    <= 1'b1;
    cp_reg_i   <= r;
    cp_op_i    <= op;
    cp_wdata_i <= d;
    @(posedge mclk_i);
    cp_wr_i <= 1'b0;
  endtask
  task automatic cp_read(input logic [3:0] r, input logic [31:0] exp);
    @(posedge mclk_i);
    cp_rd_i  <= 1'b1;
    cp_reg_i <= r;
    @(posedge mclk_i);
    cp_rd_i <= 1'b0;
    #1 check("cp read", cp_rdata_o, exp);
  endtask
  // One core access; walks_x is the number of table fetches it must cause
  task automatic probe(input logic [31:0] va, input logic dat, input logic ab_x,
                       input logic [31:0] pa_x, input int walks_x);
    int w0;
    int lat;
    w0 = u_mem.walks;
    lat = 0;
    @(posedge mclk_i);
    req_i   <= 1'b1;
    vaddr_i <= va;
    data_i  <= dat;
    @(posedge mclk_i);
    req_i <= 1'b0;
    do begin
      @(posedge mclk_i);
      #1 lat++;
    end while (ack_o !== 1'b1 && lat < 100);
    check("abort", 32'(abort_o), 32'(ab_x));
    if (!ab_x) check("paddr", paddr_o, pa_x);
    check("walks", 32'(u_mem.walks - w0), 32'(walks_x));
    if (walks_x == 0) check("latency", 32'(lat), 32'h1);
  endtask

  // ***********************
  // Scenarios
  // ***********************
  task automatic t_regs();
    cp_read(CR_CONTROL, 32'h0);
    cp_read(CR_TABLE_BASE, 32'h0);
    cp_read(CR_FAULT_STAT, 32'h0);
    cp_read(CR_FAULT_ADDR, 32'h0);
    cp_write(CR_FAULT_STAT, 3'h0, 32'hffff_ffff);
    cp_write(4'h7, 3'h0, 32'hffff_ffff);
    cp_read(CR_FAULT_STAT, 32'h0);
    cp_read(4'h7, 32'h0);
    cp_write(CR_DOMAIN, 3'h0, 32'h5a5a_000f);
    cp_read(CR_DOMAIN, 32'h5a5a_000f);
    cp_write(CR_TABLE_BASE, 3'h0, 32'h0000_4000);
    cp_read(CR_TABLE_BASE, 32'h0000_4000);
  endtask
  task automatic t_section();
    probe(32'h1234_5678, 1'b1, 1'b0, 32'h1234_5678, 0);
    cp_write(CR_CONTROL, 3'h0, 32'h1);
    u_mem.mem[30'h1123] = 32'h8000_0c1a;
    probe(32'h1230_0456, 1'b1, 1'b0, 32'h8000_0456, 1);
    check("cachable", 32'(cachable_o), 32'h1);
    check("bufferable", 32'(bufferable_o), 32'h0);
    probe(32'h123f_fffc, 1'b1, 1'b0, 32'h800f_fffc, 0);
    cp_write(CR_PROCESS_ID, 3'h0, 32'h0a00_0000);
    probe(32'h0010_0000, 1'b1, 1'b0, 32'h0a10_0000, 1);
    cp_read(CR_PROCESS_ID, 32'h0a00_0000);
    cp_write(CR_PROCESS_ID, 3'h0, 32'h0);
  endtask
  task automatic t_pages();
    u_mem.delay = 2;
    u_mem.mem[30'h1004] = 32'h0000_8031;
    u_mem.mem[30'h2003] = 32'h0012_3ff2;
    u_mem.mem[30'h1005] = 32'h0000_8431;
    u_mem.mem[30'h2112] = 32'h0abc_0ff1;
    probe(32'h0040_3abc, 1'b1, 1'b0, 32'h0012_3abc, 2);
    probe(32'h0040_3004, 1'b1, 1'b0, 32'h0012_3004, 0);
    probe(32'h0051_2345, 1'b1, 1'b0, 32'h0abc_2345, 2);
    probe(32'h0051_fffc, 1'b1, 1'b0, 32'h0abc_fffc, 0);
    u_mem.delay = 0;
  endtask
  task automatic t_faults();
    u_mem.mem[30'h1070] = 32'h0;
    u_mem.mem[30'h1071] = 32'h0;
    u_mem.mem[30'h1072] = 32'h3;
    u_mem.mem[30'h1090] = 32'h9000_0c52;
    probe(32'h0700_0010, 1'b1, 1'b1, 32'h0, 1);
    cp_read(CR_FAULT_STAT, 32'h0000_0005);
    cp_read(CR_FAULT_ADDR, 32'h0700_0010);
    probe(32'h0710_0000, 1'b0, 1'b1, 32'h0, 1);
    probe(32'h0720_0000, 1'b0, 1'b1, 32'h0, 1);
    cp_read(CR_FAULT_ADDR, 32'h0700_0010);
    probe(32'h0900_0000, 1'b1, 1'b1, 32'h0, 1);
    cp_read(CR_FAULT_STAT, 32'h0000_0029);
    cp_read(CR_FAULT_ADDR, 32'h0900_0000);
    // Client domain 10, supervisor-only section
    u_mem.mem[30'h10d0] = 32'h0d00_0552;
    priv_i <= 1'b0;
    probe(32'h0d00_0000, 1'b1, 1'b1, 32'h0, 1);
    cp_read(CR_FAULT_STAT, 32'h0000_00ad);
    priv_i <= 1'b1;
    probe(32'h0d00_0000, 1'b1, 1'b0, 32'h0d00_0000, 0);
    u_mem.err_addr = 30'h10b0;
    probe(32'h0b00_0000, 1'b1, 1'b1, 32'h0, 1);
    u_mem.err_addr = '1;
    @(posedge mclk_i);
    cp_rd_i  <= 1'b1;
    cp_reg_i <= CR_FAULT_STAT;
    @(posedge mclk_i);
    cp_rd_i <= 1'b0;
    #1 check("fault kind", cp_rdata_o & 32'hf, 32'(FS_EXT_L1));
  endtask
  task automatic t_inval();
    probe(32'h1230_0000, 1'b1, 1'b0, 32'h8000_0000, 0);
    cp_write(CR_INVALIDATE, INV_SINGLE, 32'h1230_0000);
    probe(32'h0040_3abc, 1'b1, 1'b0, 32'h0012_3abc, 0);
    probe(32'h1230_0000, 1'b1, 1'b0, 32'h8000_0000, 1);
    cp_write(CR_INVALIDATE, INV_ALL, 32'h0);
    probe(32'h0040_3abc, 1'b1, 1'b0, 32'h0012_3abc, 2);
  endtask
  // Victim pointer wraps only after every other entry was replaced
  task automatic t_round_robin();
    cp_write(CR_INVALIDATE, INV_ALL, 32'h0);
    for (int i = 0; i < TLB_ENTRIES; i++) begin
      probe({12'h200 + 12'(i), 20'h0}, 1'b1, 1'b0, {12'h200 + 12'(i), 20'h0}, 1);
    end
    probe(32'h2000_0000, 1'b1, 1'b0, 32'h2000_0000, 0);
    probe(32'h2400_0000, 1'b1, 1'b0, 32'h2400_0000, 1);
    probe(32'h2000_0000, 1'b1, 1'b0, 32'h2000_0000, 1);
  endtask

  task automatic conclude();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    #80000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_regs();
    t_section();
    t_pages();
    t_faults();
    t_inval();
    t_round_robin();
    conclude();
  end
endmodule
